/* rtl/jpic_cfg.svh */
`ifndef JPIC_CFG_SVH
`define JPIC_CFG_SVH
// instruction codes, 8-bit instruction register
`define JPIC_IR_W 8
`define JPIC_OP_EXTEST 8'h00
`define JPIC_OP_ADDR_SHIFT 8'h01
`define JPIC_OP_DATA_SHIFT 8'h02
`define JPIC_OP_DEVICE_IDENTIFICATION 8'h16
`define JPIC_OP_PROG_ENABLE 8'h15
`define JPIC_OP_PROG_DISABLE 8'h1e
`define JPIC_OP_OUT_DISABLE 8'h18
`define JPIC_OP_SIG_READ 8'h17
`define JPIC_OP_SIG_WRITE 8'h1a
`define JPIC_OP_DONE_ERASE 8'h24
`define JPIC_OP_DONE_PROG 8'h2f
`define JPIC_OP_RESET 8'h22
`define JPIC_OP_VERIFY_STEP 8'h2a
`define JPIC_OP_BYPASS 8'hff
// register widths and reset values
`define JPIC_ID_W 32
`define JPIC_SIG_W 16
`define JPIC_ADDR_W 61
`define JPIC_DATA_W 81
`define JPIC_COL_W 6
`define JPIC_ID_VALUE 32'h1234_5671
`define JPIC_SIG_RESET 16'h0000
`define JPIC_IR_CAPTURE 8'h01
`endif

/* rtl/jpic_pkg.sv */
package jpic_pkg;
  // tap controller states, sequential 4-bit encoding
  typedef enum logic [3:0] {
    JPIC_TLR = 4'h0, JPIC_RTI = 4'h1, JPIC_SEL_DR = 4'h2, JPIC_CAP_DR = 4'h3,
    JPIC_SH_DR = 4'h4, JPIC_EX1_DR = 4'h5, JPIC_PA_DR = 4'h6, JPIC_EX2_DR = 4'h7,
    JPIC_UPD_DR = 4'h8, JPIC_SEL_IR = 4'h9, JPIC_CAP_IR = 4'ha, JPIC_SH_IR = 4'hb,
    JPIC_EX1_IR = 4'hc, JPIC_PA_IR = 4'hd, JPIC_EX2_IR = 4'he, JPIC_UPD_IR = 4'hf
  } jpic_tap_state_t;
  // one-shot actions posted by the link side to the core side
  typedef struct packed {
    logic sig_write;
    logic done_erase;
    logic done_prog;
    logic seq_reset;
    logic verify_step;
  } jpic_action_t;
  // serial pins of the test port
  typedef struct packed {
    logic tms;
    logic tdi;
  } jpic_tap_in_t;
endpackage : jpic_pkg

/* rtl/jpic_tap_fsm.sv */
`timescale 1ns/1ps
// standard tap controller state machine on the test clock
module jpic_tap_fsm (
  input wire logic tck_in,
  input wire logic trst_n_in,
  input wire logic tms_in,
  output jpic_pkg::jpic_tap_state_t state_out
);
  jpic_pkg::jpic_tap_state_t state_q;
  jpic_pkg::jpic_tap_state_t state_d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    unique case (state_q)
      jpic_pkg::JPIC_TLR: state_d = tms_in ? jpic_pkg::JPIC_TLR : jpic_pkg::JPIC_RTI;
      jpic_pkg::JPIC_RTI: state_d = tms_in ? jpic_pkg::JPIC_SEL_DR : jpic_pkg::JPIC_RTI;
      jpic_pkg::JPIC_SEL_DR: state_d = tms_in ? jpic_pkg::JPIC_SEL_IR : jpic_pkg::JPIC_CAP_DR;
      jpic_pkg::JPIC_CAP_DR: state_d = tms_in ? jpic_pkg::JPIC_EX1_DR : jpic_pkg::JPIC_SH_DR;
      jpic_pkg::JPIC_SH_DR: state_d = tms_in ? jpic_pkg::JPIC_EX1_DR : jpic_pkg::JPIC_SH_DR;
      jpic_pkg::JPIC_EX1_DR: state_d = tms_in ? jpic_pkg::JPIC_UPD_DR : jpic_pkg::JPIC_PA_DR;
      jpic_pkg::JPIC_PA_DR: state_d = tms_in ? jpic_pkg::JPIC_EX2_DR : jpic_pkg::JPIC_PA_DR;
      jpic_pkg::JPIC_EX2_DR: state_d = tms_in ? jpic_pkg::JPIC_UPD_DR : jpic_pkg::JPIC_SH_DR;
      jpic_pkg::JPIC_UPD_DR: state_d = tms_in ? jpic_pkg::JPIC_SEL_DR : jpic_pkg::JPIC_RTI;
      jpic_pkg::JPIC_SEL_IR: state_d = tms_in ? jpic_pkg::JPIC_TLR : jpic_pkg::JPIC_CAP_IR;
      jpic_pkg::JPIC_CAP_IR: state_d = tms_in ? jpic_pkg::JPIC_EX1_IR : jpic_pkg::JPIC_SH_IR;
      jpic_pkg::JPIC_SH_IR: state_d = tms_in ? jpic_pkg::JPIC_EX1_IR : jpic_pkg::JPIC_SH_IR;
      jpic_pkg::JPIC_EX1_IR: state_d = tms_in ? jpic_pkg::JPIC_UPD_IR : jpic_pkg::JPIC_PA_IR;
      jpic_pkg::JPIC_PA_IR: state_d = tms_in ? jpic_pkg::JPIC_EX2_IR : jpic_pkg::JPIC_PA_IR;
      jpic_pkg::JPIC_EX2_IR: state_d = tms_in ? jpic_pkg::JPIC_UPD_IR : jpic_pkg::JPIC_SH_IR;
      jpic_pkg::JPIC_UPD_IR: state_d = tms_in ? jpic_pkg::JPIC_SEL_DR : jpic_pkg::JPIC_RTI;
    endcase
  end

  // ------------------------------------------------------------
  // state register; trst gives test-logic-reset at the next rising tck edge
  // ------------------------------------------------------------
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      state_q <= jpic_pkg::JPIC_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_out = state_q;
endmodule : jpic_tap_fsm

/* rtl/jpic_ctrl.sv */
`timescale 1ns/1ps
`include "jpic_cfg.svh"
// ------------------------------------------------------------
// test port instruction control: program mode, signature, done flag
// ------------------------------------------------------------
// Summary of operation
// - program-disable instruction leaves programming mode
// - test-logic-reset state also cancels programming mode
// - signature-read loads stored signature and selects it between tdi and tdo
// - signature-write in programming mode stores the signature register into nonvolatile storage
// - signature-write forces all outputs to the disabled state
// - done-erase clears done flag; sequence cannot start while clear
// - done-program sets done flag, letting the sequence start
// - reset instruction resets array sequence and all output cells
// - after reset instruction done flag, verify address and programming mode keep their values
// - verify-step shifts out array data for current column address
// - after each verify-step read the array address advances by one
// - output-disable state tri-states every digital and gate-driver output
// - signature-read code 0x17, signature-write code 0x1a
// - done-erase code 0x24, done-program code 0x2f
// - verify-step code 0x2a, loads column register from storage
// - program-enable enters programming mode and disables outputs
module jpic_ctrl (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic tck_in,
  input wire logic trst_n_in,
  input jpic_pkg::jpic_tap_in_t tap_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic [`JPIC_SIG_W-1:0] nv_signature_in,
  output logic nv_sig_write_out,
  output logic [`JPIC_SIG_W-1:0] nv_sig_data_out,
  output logic [`JPIC_COL_W-1:0] array_addr_out,
  input wire logic [`JPIC_DATA_W-1:0] array_col_data_in,
  output logic prog_mode_out,
  output logic outputs_disabled_out,
  output logic done_flag_out,
  output logic seq_start_ok_out,
  output logic seq_reset_out
);
  // ------------------------------------------------------------
  // link side: tap controller and instruction register (tck domain)
  // ------------------------------------------------------------
  jpic_pkg::jpic_tap_state_t tap_state;
  logic [`JPIC_IR_W-1:0] ir_shift_q;
  logic [`JPIC_IR_W-1:0] ir_q;
  logic [`JPIC_DATA_W-1:0] dr_shift_q;
  logic prog_mode_q;
  logic tdo_q;
  logic tdo_en_q;
  logic sig_wr_tgl_q;
  logic erase_tgl_q;
  logic dprog_tgl_q;
  logic rst_tgl_q;
  logic step_tgl_q;
  logic [`JPIC_SIG_W-1:0] sig_shadow_q;
  // storage words crossing in from the core side, and the word going back
  logic [`JPIC_SIG_W-1:0] nv_sig_q1;
  logic [`JPIC_SIG_W-1:0] nv_sig_q2;
  logic [`JPIC_SIG_W-1:0] nv_sig_q3;
  logic [`JPIC_SIG_W-1:0] nv_sig_hold_q;
  logic [`JPIC_DATA_W-1:0] col_q1;
  logic [`JPIC_DATA_W-1:0] col_q2;
  logic [`JPIC_DATA_W-1:0] col_q3;
  logic [`JPIC_DATA_W-1:0] col_hold_q;
  logic [`JPIC_SIG_W-1:0] nv_hold_q;

  jpic_tap_fsm u_tap (
    .tck_in(tck_in),
    .trst_n_in(trst_n_in),
    .tms_in(tap_in.tms),
    .state_out(tap_state)
  );

  wire in_tlr = (tap_state == jpic_pkg::JPIC_TLR);
  wire upd_ir = (tap_state == jpic_pkg::JPIC_UPD_IR);
  wire upd_dr = (tap_state == jpic_pkg::JPIC_UPD_DR);
  wire cap_dr = (tap_state == jpic_pkg::JPIC_CAP_DR);
  wire sh_dr = (tap_state == jpic_pkg::JPIC_SH_DR);
  wire in_rti = (tap_state == jpic_pkg::JPIC_RTI);

  // instruction shift and update; tlr selects device_identification
  always_ff @(posedge tck_in) begin
    if (!trst_n_in || in_tlr) begin
      ir_shift_q <= `JPIC_IR_CAPTURE;
      ir_q <= `JPIC_OP_DEVICE_IDENTIFICATION;
    end else if (tap_state == jpic_pkg::JPIC_CAP_IR) begin
      ir_shift_q <= `JPIC_IR_CAPTURE;
    end else if (tap_state == jpic_pkg::JPIC_SH_IR) begin
      ir_shift_q <= {tap_in.tdi, ir_shift_q[`JPIC_IR_W-1:1]};
    end else if (upd_ir) begin
      ir_q <= ir_shift_q;
    end
  end

  // programming mode flag
  always_ff @(posedge tck_in) begin
    if (!trst_n_in || in_tlr) begin
      prog_mode_q <= 1'b0;
    end else if (upd_ir && ir_shift_q == `JPIC_OP_PROG_ENABLE) begin
      prog_mode_q <= 1'b1;
    end else if (upd_ir && ir_shift_q == `JPIC_OP_PROG_DISABLE) begin
      prog_mode_q <= 1'b0;
    end
  end

  // selected data register width, lsb nearest tdo
  logic [6:0] dr_len;
  always_comb begin
    unique case (ir_q)
      `JPIC_OP_DEVICE_IDENTIFICATION: dr_len = 7'd32;
      `JPIC_OP_SIG_READ,
      `JPIC_OP_SIG_WRITE: dr_len = 7'd16;
      `JPIC_OP_VERIFY_STEP,
      `JPIC_OP_DATA_SHIFT: dr_len = 7'd81;
      `JPIC_OP_ADDR_SHIFT: dr_len = 7'd61;
      default: dr_len = 7'd1; // bypass for everything else
    endcase
  end

  // one shared shift path; shifting fills from the top of the selected length
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      dr_shift_q <= '0;
    end else if (cap_dr) begin
      unique case (ir_q)
        `JPIC_OP_DEVICE_IDENTIFICATION: dr_shift_q <= {49'h0, `JPIC_ID_VALUE};
        `JPIC_OP_SIG_READ: dr_shift_q <= {65'h0, nv_sig_hold_q};
        `JPIC_OP_SIG_WRITE: dr_shift_q <= {65'h0, sig_shadow_q};
        `JPIC_OP_VERIFY_STEP: dr_shift_q <= col_hold_q;
        default: dr_shift_q <= '0;
      endcase
    end else if (sh_dr) begin
      dr_shift_q <= dr_shift_q >> 1;
      dr_shift_q[dr_len-7'd1] <= tap_in.tdi;
    end
  end

  // signature register update from the shift path
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      sig_shadow_q <= `JPIC_SIG_RESET;
    end else if (cap_dr && ir_q == `JPIC_OP_SIG_READ) begin
      sig_shadow_q <= nv_sig_hold_q;
    end else if (upd_dr && (ir_q == `JPIC_OP_SIG_READ || ir_q == `JPIC_OP_SIG_WRITE)) begin
      sig_shadow_q <= dr_shift_q[`JPIC_SIG_W-1:0];
    end
  end

  // tdo changes on the falling edge as usual for a tap
  always_ff @(negedge tck_in) begin
    if (!trst_n_in) begin
      tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_q <= (tap_state == jpic_pkg::JPIC_SH_IR) ? ir_shift_q[0] : dr_shift_q[0];
      tdo_en_q <= sh_dr || (tap_state == jpic_pkg::JPIC_SH_IR);
    end
  end

  // ------------------------------------------------------------
  // link side: one toggle per command, crossed by its level
  // ------------------------------------------------------------
  // a toggle rather than a pulse, so the core side never misses one
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      erase_tgl_q <= 1'b0;
      dprog_tgl_q <= 1'b0;
      rst_tgl_q <= 1'b0;
    end else begin
      if (upd_ir && ir_shift_q == `JPIC_OP_DONE_ERASE) begin
        erase_tgl_q <= ~erase_tgl_q;
      end
      if (upd_ir && ir_shift_q == `JPIC_OP_DONE_PROG) begin
        dprog_tgl_q <= ~dprog_tgl_q;
      end
      if (upd_ir && ir_shift_q == `JPIC_OP_RESET) begin
        rst_tgl_q <= ~rst_tgl_q;
      end
    end
  end

  // signature-write fires on each test clock spent in run-test-idle while in programming mode
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      sig_wr_tgl_q <= 1'b0;
    end else if (in_rti && ir_q == `JPIC_OP_SIG_WRITE && prog_mode_q) begin
      sig_wr_tgl_q <= ~sig_wr_tgl_q;
    end
  end

  // every completed column scan moves the verify address on
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      step_tgl_q <= 1'b0;
    end else if (upd_dr && ir_q == `JPIC_OP_VERIFY_STEP) begin
      step_tgl_q <= ~step_tgl_q;
    end
  end

  // output disable for the instructions that force it; held as a level
  logic odis_q;
  always_ff @(posedge tck_in) begin
    if (!trst_n_in || in_tlr) begin
      odis_q <= 1'b0;
    end else if (upd_ir) begin
      unique case (ir_shift_q)
        `JPIC_OP_OUT_DISABLE, `JPIC_OP_SIG_WRITE, `JPIC_OP_PROG_ENABLE,
        `JPIC_OP_ADDR_SHIFT, `JPIC_OP_DATA_SHIFT: odis_q <= 1'b1;
        default: odis_q <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // core to link: signature and column data synchronised into tck
  // ------------------------------------------------------------
  // storage levels pass three stages on the test clock
  always_ff @(posedge tck_in) begin
    nv_sig_q1 <= nv_signature_in;
    nv_sig_q2 <= nv_sig_q1;
    nv_sig_q3 <= nv_sig_q2;
    col_q1 <= array_col_data_in;
    col_q2 <= col_q1;
    col_q3 <= col_q2;
  end

  // a word is taken only once stages two and three agree, so a capture never
  // mixes old and new bits; the price is one more test clock of latency
  always_ff @(posedge tck_in) begin
    if (!trst_n_in) begin
      nv_sig_hold_q <= `JPIC_SIG_RESET;
      col_hold_q <= '0;
    end else begin
      if (nv_sig_q2 == nv_sig_q3) begin
        nv_sig_hold_q <= nv_sig_q3;
      end
      if (col_q2 == col_q3) begin
        col_hold_q <= col_q3;
      end
    end
  end

  // ------------------------------------------------------------
  // core side: three-flop capture of link events and levels
  // ------------------------------------------------------------
  logic [6:0] lvl1_q;
  logic [6:0] lvl2_q;
  logic [6:0] lvl3_q;
  logic [6:0] lvl_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      lvl1_q <= 7'h00;
      lvl2_q <= 7'h00;
      lvl3_q <= 7'h00;
      lvl_q <= 7'h00;
    end else begin
      lvl1_q <= {prog_mode_q, odis_q, sig_wr_tgl_q, erase_tgl_q, dprog_tgl_q,
                 rst_tgl_q, step_tgl_q};
      lvl2_q <= lvl1_q;
      lvl3_q <= lvl2_q;
      // a change counts once second and third stages agree
      for (int i = 0; i < 7; i++) begin
        if (lvl2_q[i] == lvl3_q[i]) begin
          lvl_q[i] <= lvl3_q[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // core side: one-shot actions, done flag and verify address
  // ------------------------------------------------------------
  logic [4:0] tgl_prev_q;
  jpic_pkg::jpic_action_t act;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tgl_prev_q <= 5'h00;
    end else begin
      tgl_prev_q <= lvl_q[4:0];
    end
  end
  assign act = jpic_pkg::jpic_action_t'(lvl_q[4:0] ^ tgl_prev_q);

  // done flag; program beats erase when both arrive in one cycle. the reset
  // instruction leaves it alone: it mirrors a stored bit, not sequence state
  logic done_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      done_q <= 1'b1; // power-on value: sequence allowed
    end else if (act.done_prog) begin
      done_q <= 1'b1;
    end else if (act.done_erase) begin
      done_q <= 1'b0;
    end
  end

  // array column address stepping
  logic [`JPIC_COL_W-1:0] addr_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      addr_q <= '0;
    end else if (act.verify_step) begin
      addr_q <= addr_q + `JPIC_COL_W'(1);
    end
  end

  // signature write strobe and data
  logic sig_wr_q;
  logic seq_rst_q;
  logic [`JPIC_SIG_W-1:0] sig_out_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sig_wr_q <= 1'b0;
      seq_rst_q <= 1'b0;
      sig_out_q <= `JPIC_SIG_RESET;
    end else begin
      sig_wr_q <= act.sig_write;
      seq_rst_q <= act.seq_reset;
      if (act.sig_write) begin
        sig_out_q <= nv_hold_q;
      end
    end
  end

  // signature word sampled straight from the link side: it has stood still for
  // many test clocks by the time the write toggle has crossed, so no mix occurs
  always_ff @(posedge core_clk_in) begin
    nv_hold_q <= sig_shadow_q; // static by the time the toggle has crossed
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign tdo_out = tdo_q;
  assign tdo_oe_n_out = ~tdo_en_q;
  assign nv_sig_write_out = sig_wr_q;
  assign nv_sig_data_out = sig_out_q;
  assign array_addr_out = addr_q;
  assign prog_mode_out = lvl_q[6];
  assign outputs_disabled_out = lvl_q[5];
  assign done_flag_out = done_q;
  assign seq_start_ok_out = done_q;
  assign seq_reset_out = seq_rst_q;
endmodule : jpic_ctrl

/* tb/jpic_ctrl_sva.sv */
`timescale 1ns/1ps
`include "jpic_cfg.svh"
// ----------------------------------------
// port checks for the instruction control
// ----------------------------------------
module jpic_ctrl_sva (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic tck_in,
  input wire logic trst_n_in,
  input wire logic tdo_oe_n_out,
  input wire logic nv_sig_write_out,
  input wire logic [`JPIC_COL_W-1:0] array_addr_out,
  input wire logic prog_mode_out,
  input wire logic outputs_disabled_out,
  input wire logic done_flag_out,
  input wire logic seq_start_ok_out,
  input wire logic seq_reset_out
);
  // tap reset reaches the core side within 12 core clock cycles
  sequence s_prog_off;
    ##[1:12] !prog_mode_out;
  endsequence
  // flag clear for two cycles; seq_start_ok_out is the flag itself, no register stage behind it
  sequence s_flag_clear;
    !done_flag_out [*2];
  endsequence
  chk_start_gate: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_flag_clear |-> !seq_start_ok_out) else $error("start allowed while done clear");
  chk_prog_odis: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $rose(prog_mode_out) |-> ##[0:2] outputs_disabled_out) else $error("prog without disable");
  chk_write_prog: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    nv_sig_write_out |-> prog_mode_out) else $error("write outside prog mode");
  chk_write_odis: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    nv_sig_write_out |-> outputs_disabled_out) else $error("write with outputs on");
  chk_write_pulse: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    nv_sig_write_out |=> !nv_sig_write_out) else $error("write strobe too long");
  chk_reset_pulse: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_reset_out |=> !seq_reset_out) else $error("reset strobe too long");
  chk_reset_done: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_reset_out |-> $stable(done_flag_out)) else $error("reset instruction moved done flag");
  chk_addr_step: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $changed(array_addr_out) && array_addr_out != 6'h00 |->
    array_addr_out == 6'($past(array_addr_out) + 6'h01)) else $error("address skipped");
  chk_trst_cancel: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $fell(trst_n_in) |-> s_prog_off) else $error("tap reset kept prog mode");
  chk_tdo_idle: assert property (@(posedge tck_in) disable iff (!trst_n_in)
    !$past(trst_n_in) |-> tdo_oe_n_out) else $error("tdo driven after tap reset");
endmodule : jpic_ctrl_sva

/* tb/jpic_tap_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// test port host, tck runs only in frames
// ----------------------------------------
module jpic_tap_host (
  output logic tck_out,
  output logic trst_n_out,
  output jpic_pkg::jpic_tap_in_t tap_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_n_in
);
  logic so;
  initial begin
    tck_out = 1'b0;
    trst_n_out = 1'b0;
    tap_out = 2'h0;
  end
  // one tck period; tdo taken just before the rising edge
  task automatic tick(input logic ms, input logic di);
    tap_out.tms = ms;
    tap_out.tdi = di;
    #15 so = tdo_oe_n_in ? 1'b1 : tdo_in; // released line rests at its pull-up
    tck_out = 1'b1;
    #15 tck_out = 1'b0;
  endtask : tick
  // tms held high walks to test-logic-reset, optionally with trst too
  task automatic tap_reset(input logic hard);
    trst_n_out = !hard;
    repeat (5) tick(1'b1, ~tap_out.tdi);
    trst_n_out = 1'b1;
    tick(1'b0, ~tap_out.tdi);
  endtask : tap_reset
  // ir or dr scan from run-test-idle back to run-test-idle
  task automatic scan(input logic ir, input int n, input logic [80:0] din,
                      output logic [80:0] dout);
    dout = 81'h0;
    tick(1'b1, ~tap_out.tdi);
    if (ir) tick(1'b1, ~tap_out.tdi);
    tick(1'b0, ~tap_out.tdi);
    tick(1'b0, ~tap_out.tdi);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = so;
    end
    tick(1'b1, ~tap_out.tdi);
    tick(1'b0, ~tap_out.tdi);
  endtask : scan
  // idle tdi toggles so a stale level never looks valid
  task automatic idle(input int n);
    repeat (n) tick(1'b0, ~tap_out.tdi);
  endtask : idle
endmodule : jpic_tap_host

/* tb/jpic_ctrl_tb.sv */
`timescale 1ns/1ps
`include "jpic_cfg.svh"
// ----------------------------------------
// bench top
// ----------------------------------------
module jpic_ctrl_tb;
  logic core_clk_in, resetn_in, tck, trst_n, tdo, tdo_oe_n;
  logic wr, prog, odis, done, start_ok, sreset;
  jpic_pkg::jpic_tap_in_t tap;
  logic [15:0] nv_sig, sig_data;
  logic [80:0] col, dout;
  logic [5:0] addr;
  logic [7:0] code;
  int error_cnt = 0;
  int checks = 0;
  int wr_cnt = 0;
  int rst_cnt = 0;
  jpic_ctrl uut (.core_clk_in, .resetn_in, .tck_in(tck), .trst_n_in(trst_n), .tap_in(tap),
    .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .nv_signature_in(nv_sig),
    .nv_sig_write_out(wr), .nv_sig_data_out(sig_data), .array_addr_out(addr),
    .array_col_data_in(col), .prog_mode_out(prog), .outputs_disabled_out(odis),
    .done_flag_out(done), .seq_start_ok_out(start_ok), .seq_reset_out(sreset));
  jpic_tap_host host (.tck_out(tck), .trst_n_out(trst_n), .tap_out(tap), .tdo_in(tdo),
    .tdo_oe_n_in(tdo_oe_n));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // strobes last one cycle, so count them as they pass
  always @(posedge core_clk_in) begin
    wr_cnt <= wr_cnt + int'(wr === 1'b1);
    rst_cnt <= rst_cnt + int'(sreset === 1'b1);
  end
  task automatic chk(input string nm, input logic [80:0] seen, input logic [80:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // load an instruction, then let the crossing settle
  task automatic op(input logic [7:0] c);
    logic [80:0] d;
    host.scan(1'b1, 8, {73'h0, c}, d);
    repeat (10) @(posedge core_clk_in);
  endtask : op
  function automatic logic exp_done(input logic [7:0] c, input logic prev);
    return c == `JPIC_OP_DONE_PROG ? 1'b1 : c == `JPIC_OP_DONE_ERASE ? 1'b0 : prev;
  endfunction : exp_done
  initial begin
    logic [15:0] s;
    logic [5:0] a;
    logic e;
    int n;
    n = $urandom(32'h2a3b);
    resetn_in = 1'b0;
    nv_sig = 16'h0;
    col = 81'h0;
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    host.tap_reset(1'b1);
    repeat (10) @(posedge core_clk_in);
    chk("done_init", done, 1'b1);
    host.scan(1'b0, 32, 81'h0, dout);
    chk("device_identification", dout[31:0], `JPIC_ID_VALUE);
    // signature read, then a write refused outside programming mode
    @(posedge core_clk_in) nv_sig <= 16'($urandom);
    op(`JPIC_OP_SIG_READ);
    s = 16'($urandom);
    host.scan(1'b0, 16, {65'h0, s}, dout);
    chk("sig_read", dout[15:0], nv_sig);
    n = wr_cnt;
    op(`JPIC_OP_SIG_WRITE);
    host.idle(2);
    repeat (10) @(posedge core_clk_in);
    chk("wr_refused", 81'(wr_cnt - n), 81'h0);
    // programming mode: shift a new signature and store it
    op(`JPIC_OP_PROG_ENABLE);
    chk("prog_on", prog, 1'b1);
    chk("odis_on", odis, 1'b1);
    op(`JPIC_OP_SIG_READ);
    host.scan(1'b0, 16, {65'h0, s}, dout);
    n = wr_cnt;
    op(`JPIC_OP_SIG_WRITE);
    host.idle(1);
    repeat (10) @(posedge core_clk_in);
    chk("wr_taken", wr_cnt > n, 1'b1);
    chk("sig_data", sig_data, s);
    chk("odis_wr", odis, 1'b1);
    // done flag: erase before program, then a random walk
    e = done;
    for (int i = 0; i < 8; i++) begin
      code = i == 0 ? `JPIC_OP_DONE_ERASE : i == 1 ? `JPIC_OP_DONE_PROG :
        $urandom_range(1) ? `JPIC_OP_DONE_PROG : `JPIC_OP_DONE_ERASE;
      op(code);
      e = exp_done(code, e);
      chk("done", done, e);
      if (!e) chk("start_ok", start_ok, 1'b0);
    end
    // leaving programming mode blocks later writes
    op(`JPIC_OP_PROG_DISABLE);
    chk("prog_off", prog, 1'b0);
    n = wr_cnt;
    op(`JPIC_OP_SIG_WRITE);
    host.idle(2);
    repeat (10) @(posedge core_clk_in);
    chk("wr_after_off", 81'(wr_cnt - n), 81'h0);
    // verify steps read a column each and advance the address
    op(`JPIC_OP_VERIFY_STEP);
    repeat (3) begin
      a = addr;
      @(posedge core_clk_in) col <= 81'({$urandom, $urandom, $urandom});
      @(posedge core_clk_in);
      host.idle(2); // column word must settle through the link-side stages
      host.scan(1'b0, 81, 81'h0, dout);
      repeat (10) @(posedge core_clk_in);
      chk("column", dout, col);
      chk("addr", addr, 6'(a + 6'h01));
    end
    // reset instruction gives one strobe and leaves outputs enabled
    n = rst_cnt;
    op(`JPIC_OP_RESET);
    chk("seq_reset", 81'(rst_cnt - n), 81'h1);
    chk("odis_rst", odis, 1'b0);
    chk("done_rst", done, e);
    // test-logic-reset by tms alone and by trst both cancel prog mode
    op(`JPIC_OP_PROG_ENABLE);
    host.tap_reset(1'b0);
    repeat (10) @(posedge core_clk_in);
    chk("tlr_tms", prog, 1'b0);
    op(`JPIC_OP_PROG_ENABLE);
    host.tap_reset(1'b1);
    repeat (10) @(posedge core_clk_in);
    chk("tlr_trst", prog, 1'b0);
    results();
  end
  // the whole run needs well under this span
  initial begin
    #200_000;
    error_cnt++;
    results();
  end
endmodule : jpic_ctrl_tb
bind jpic_ctrl jpic_ctrl_sva u_chk (.core_clk_in, .resetn_in, .tck_in, .trst_n_in,
  .tdo_oe_n_out, .nv_sig_write_out, .array_addr_out, .prog_mode_out, .outputs_disabled_out,
  .done_flag_out, .seq_start_ok_out, .seq_reset_out);
